// *** hdl/irq_controller.sv ***
`timescale 1ns/1ps
module irq_controller
  import irq_ctrl_pkg::*;
(
  // Clock, reset and machine-cycle enable.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic machineCycleEn,
  // Source flags, enables and priority registers.
  input wire flags_type flags,
  input wire enables_type enables,
  input wire prio_regs_type prios,
  // Source configuration.
  input wire logic extPinAEdgeMode,
  input wire logic extPinBEdgeMode,
  input wire logic watchdogRcClock,
  input wire logic converterRcClock,
  // Core sequencer status and stack view.
  input wire core_step_type coreStep,
  input wire logic [15:0] programCounter,
  input wire logic [15:0] stackTop,
  // Vector call towards the core.
  output logic vectorCall,
  output logic [15:0] vectorAddr,
  output logic stackPushReq,
  output logic [15:0] stackPushValue,
  // Program counter reload on return.
  output logic pcLoad,
  output logic [15:0] pcLoadValue,
  // Hardware flag clears towards the source peripherals.
  output logic timerAOverflowClear,
  output logic timerBOverflowClear,
  output logic extPinAClear,
  output logic extPinBClear,
  // Power-down wake and status.
  output logic wakeRequest,
  output logic [NUM_LEVELS-1:0] inService,
  output logic [1:0] serviceLevel
);

  ////////////////////////////////////////////////////////////////////////////
  // Request formation.
  ////////////////////////////////////////////////////////////////////////////

  logic [NUM_SOURCES-1:0] rawRequest;
  logic [NUM_SOURCES-1:0] request;
  logic [23:0] prioLowImage;
  logic [23:0] prioHighImage;
  logic [2*NUM_SOURCES-1:0] levels;
  logic winValid;
  logic [4:0] winIndex;
  logic [1:0] winLevel;
  logic serviceAny;
  logic [1:0] serviceTop;
  logic preemptOk;
  logic takeVector;
  logic next_wake;

  // Shared flags of one source merge into a single request line.
  always_comb begin
    rawRequest = '0;
    rawRequest[SRC_EXT_A] = flags.extPinAFlag & enables.extPinAEnable;
    rawRequest[SRC_BROWNOUT] = flags.brownoutFlag & enables.brownoutEnable;
    rawRequest[SRC_WATCHDOG] =
      flags.watchdogTimeoutFlag & enables.watchdogIrqEnable;
    rawRequest[SRC_TIMER_A] = flags.timerAOverflowFlag & enables.timerAEnable;
    rawRequest[SRC_SPI] = (flags.spiDoneFlag | flags.spiModeFaultFlag |
      flags.spiOverrunFlag) & enables.spiIrqEnable;
    rawRequest[SRC_I2C] = flags.i2cFlag & enables.i2cIrqEnable;
    rawRequest[SRC_CONVERTER] =
      (flags.converterDoneFlag & enables.converterDoneEnable) |
      (flags.converterCompareFlag & enables.converterCompareEnable);
    rawRequest[SRC_EXT_B] = flags.extPinBFlag & enables.extPinBEnable;
    rawRequest[SRC_KEYPAD] = flags.keypadFlag & enables.keypadIrqEnable;
    rawRequest[SRC_COMPARATOR] = (flags.comparatorAFlag |
      flags.comparatorBFlag) & enables.comparatorIrqEnable;
    rawRequest[SRC_TIMER_B] = flags.timerBOverflowFlag & enables.timerBEnable;
    rawRequest[SRC_SERIAL] =
      (flags.serialRxFlag | flags.serialTxFlag) & enables.serialEnable;
    rawRequest[SRC_TIMER_C] = flags.timerCEventFlag & enables.timerCEnable;
    rawRequest[SRC_BRAKE] =
      (flags.brakeAFlag | flags.brakeBFlag) & enables.brakeIrqEnable;
    rawRequest[SRC_CAPTURE] = (|flags.captureFlags) & enables.captureIrqEnable;
    rawRequest[SRC_TIMER_D] = flags.timerDEventFlag & enables.timerDEnable;
    rawRequest[SRC_PWM] = flags.pwmPeriodFlag & enables.pwmIrqEnable;
  end

  // The global enable overrides every individual enable.
  assign request = rawRequest
    & {NUM_SOURCES{enables.globalIrqEnable}};

  ////////////////////////////////////////////////////////////////////////////
  // Priority levels and arbitration.
  ////////////////////////////////////////////////////////////////////////////

  assign prioLowImage = {prios.prioLowReg2, prios.prioLowReg1,
    prios.prioLowReg0};
  assign prioHighImage = {prios.prioHighReg2, prios.prioHighReg1,
    prios.prioHighReg0};

  // High bit above low bit forms the level, so 11 is level 3 and 00 level 0.
  always_comb begin
    levels = '0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      levels[2*i +: 2] = {prioHighImage[prio_pos(5'(i))],
        prioLowImage[prio_pos(5'(i))]};
    end
  end

  // Pure combinational arbitration on the flags present this cycle.
  irq_priority_resolver resolver (
    .request(request),
    .levels(levels),
    .winValid(winValid),
    .winIndex(winIndex),
    .winLevel(winLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Vectoring decision.
  ////////////////////////////////////////////////////////////////////////////

  // Highest level whose routine is still marked in service.
  always_comb begin
    serviceAny = |inService;
    serviceTop = 2'h0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (inService[l]) begin
        serviceTop = 2'(l);
      end
    end
  end

  // A running level 3 routine can never be beaten, since no level exceeds it.
  assign preemptOk = !serviceAny || (winLevel > serviceTop);

  // The request is judged afresh each machine cycle and never stored, so a
  // flag that drops before the gating conditions open is simply lost.
  assign takeVector = machineCycleEn && winValid && preemptOk
    && coreStep.lastCycle
    && !coreStep.blockVector
    && !coreStep.returnFromInterrupt;

  ////////////////////////////////////////////////////////////////////////////
  // Vector call outputs.
  ////////////////////////////////////////////////////////////////////////////

  // One-machine-cycle call pulse with the routine address and the return
  // address. The status word is never part of the push.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vectorCall <= 1'b0;
      vectorAddr <= PC_RESET;
      stackPushReq <= 1'b0;
      stackPushValue <= PC_RESET;
    end else if (machineCycleEn) begin
      vectorCall <= takeVector;
      stackPushReq <= takeVector;
      if (takeVector) begin
        vectorAddr <= vector_of(winIndex);
        stackPushValue <= programCounter;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter reload on return.
  ////////////////////////////////////////////////////////////////////////////

  // Both kinds of return reload the counter from the stack top alike; only the
  // call blocking above and the in-service bookkeeping below tell them apart.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcLoad <= 1'b0;
      pcLoadValue <= PC_RESET;
    end else if (machineCycleEn) begin
      pcLoad <= coreStep.returnFromInterrupt | coreStep.plainReturn;
      if (coreStep.returnFromInterrupt || coreStep.plainReturn) begin
        pcLoadValue <= stackTop;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // In-service tracking.
  ////////////////////////////////////////////////////////////////////////////

  // Return-from-interrupt retires the highest marked level, which is the
  // routine now running unless a higher one was left by plain return. A plain
  // return leaves the marks alone, so a routine left by plain return keeps
  // blocking its own and lower levels. Return-from-interrupt also blocks a
  // new call in the same cycle, so set and clear never meet.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inService <= IN_SERVICE_RESET;
      serviceLevel <= 2'h0;
    end else if (machineCycleEn) begin
      if (takeVector) begin
        inService[winLevel] <= 1'b1;
        serviceLevel <= winLevel;
      end else if (coreStep.returnFromInterrupt && serviceAny) begin
        inService[serviceTop] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware flag clears.
  ////////////////////////////////////////////////////////////////////////////

  // Only timer 0, timer 1 and edge-mode external pins are cleared here; a
  // level-mode pin must stay visible while the source holds it low. Every
  // other flag is left for software.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerAOverflowClear <= 1'b0;
      timerBOverflowClear <= 1'b0;
      extPinAClear <= 1'b0;
      extPinBClear <= 1'b0;
    end else if (machineCycleEn) begin
      timerAOverflowClear <= takeVector && winIndex == SRC_TIMER_A;
      timerBOverflowClear <= takeVector && winIndex == SRC_TIMER_B;
      extPinAClear <= takeVector && winIndex == SRC_EXT_A
        && extPinAEdgeMode;
      extPinBClear <= takeVector && winIndex == SRC_EXT_B
        && extPinBEdgeMode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down wake.
  ////////////////////////////////////////////////////////////////////////////

  // Enabled wake-capable requests only. The converter compare flag is left
  // out altogether, and clocked sources need the internal RC oscillator,
  // because any other clock is stopped in power down.
  always_comb begin
    next_wake = request[SRC_EXT_A] | request[SRC_EXT_B]
      | request[SRC_BROWNOUT] | request[SRC_KEYPAD]
      | request[SRC_COMPARATOR]
      | (request[SRC_WATCHDOG] & watchdogRcClock)
      | (enables.globalIrqEnable & enables.converterDoneEnable
         & flags.converterDoneFlag & converterRcClock);
  end

  // Wake is sampled even with the machine-cycle enable low, since a halted
  // core in power down gives no machine cycles.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeRequest <= 1'b0;
    end else begin
      wakeRequest <= next_wake;
    end
  end

endmodule : irq_controller

// *** hdl/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;

  localparam int NUM_SOURCES = 17;
  localparam int NUM_LEVELS = 4;

  // Sources in arbitration rank order, index 0 wins ties.
  localparam logic [4:0] SRC_EXT_A = 5'h00;
  localparam logic [4:0] SRC_BROWNOUT = 5'h01;
  localparam logic [4:0] SRC_WATCHDOG = 5'h02;
  localparam logic [4:0] SRC_TIMER_A = 5'h03;
  localparam logic [4:0] SRC_SPI = 5'h04;
  localparam logic [4:0] SRC_I2C = 5'h05;
  localparam logic [4:0] SRC_CONVERTER = 5'h06;
  localparam logic [4:0] SRC_EXT_B = 5'h07;
  localparam logic [4:0] SRC_KEYPAD = 5'h08;
  localparam logic [4:0] SRC_COMPARATOR = 5'h09;
  localparam logic [4:0] SRC_TIMER_B = 5'h0a;
  localparam logic [4:0] SRC_SERIAL = 5'h0b;
  localparam logic [4:0] SRC_TIMER_C = 5'h0c;
  localparam logic [4:0] SRC_BRAKE = 5'h0d;
  localparam logic [4:0] SRC_CAPTURE = 5'h0e;
  localparam logic [4:0] SRC_TIMER_D = 5'h0f;
  localparam logic [4:0] SRC_PWM = 5'h10;

  // Bit position of each source inside the 24-bit priority register image.
  // Register pair n occupies bits 8n+7 down to 8n.
  localparam logic [4:0] PRIO_REG_1_BASE = 5'h08;
  localparam logic [4:0] PRIO_REG_2_BASE = 5'h10;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] IN_SERVICE_RESET = 4'h0;

  typedef struct packed {
    logic extPinAFlag;
    logic extPinBFlag;
    logic timerAOverflowFlag;
    logic timerBOverflowFlag;
    logic timerCEventFlag;
    logic timerDEventFlag;
    logic serialRxFlag;
    logic serialTxFlag;
    logic brownoutFlag;
    logic watchdogTimeoutFlag;
    logic i2cFlag;
    logic spiDoneFlag;
    logic spiModeFaultFlag;
    logic spiOverrunFlag;
    logic converterDoneFlag;
    logic converterCompareFlag;
    logic keypadFlag;
    logic comparatorAFlag;
    logic comparatorBFlag;
    logic brakeAFlag;
    logic brakeBFlag;
    logic [2:0] captureFlags;
    logic pwmPeriodFlag;
  } flags_type;

  typedef struct packed {
    logic globalIrqEnable;
    logic extPinAEnable;
    logic extPinBEnable;
    logic timerAEnable;
    logic timerBEnable;
    logic timerCEnable;
    logic timerDEnable;
    logic serialEnable;
    logic brownoutEnable;
    logic watchdogIrqEnable;
    logic i2cIrqEnable;
    logic spiIrqEnable;
    logic converterDoneEnable;
    logic converterCompareEnable;
    logic keypadIrqEnable;
    logic comparatorIrqEnable;
    logic brakeIrqEnable;
    logic captureIrqEnable;
    logic pwmIrqEnable;
  } enables_type;

  typedef struct packed {
    logic [7:0] prioHighReg2;
    logic [7:0] prioHighReg1;
    logic [7:0] prioHighReg0;
    logic [7:0] prioLowReg2;
    logic [7:0] prioLowReg1;
    logic [7:0] prioLowReg0;
  } prio_regs_type;

  typedef struct packed {
    logic lastCycle;
    logic blockVector;
    logic returnFromInterrupt;
    logic plainReturn;
  } core_step_type;

  // Fixed entry address of each source's service routine.
  function automatic logic [15:0] vector_of(input logic [4:0] src);
    logic [15:0] addr;
    addr = 16'h0003;
    case (src)
      SRC_EXT_A: addr = 16'h0003;
      SRC_TIMER_A: addr = 16'h000b;
      SRC_EXT_B: addr = 16'h0013;
      SRC_TIMER_B: addr = 16'h001b;
      SRC_SERIAL: addr = 16'h0023;
      SRC_BROWNOUT: addr = 16'h002b;
      SRC_I2C: addr = 16'h0033;
      SRC_KEYPAD: addr = 16'h003b;
      SRC_SPI: addr = 16'h004b;
      SRC_WATCHDOG: addr = 16'h0053;
      SRC_CONVERTER: addr = 16'h005b;
      SRC_COMPARATOR: addr = 16'h0063;
      SRC_CAPTURE: addr = 16'h006b;
      SRC_PWM: addr = 16'h0073;
      SRC_TIMER_C: addr = 16'h007b;
      SRC_BRAKE: addr = 16'h0083;
      SRC_TIMER_D: addr = 16'h008b;
      default: addr = 16'h0003;
    endcase
    return addr;
  endfunction : vector_of

  // Position of a source's bit within the paired priority registers.
  function automatic logic [4:0] prio_pos(input logic [4:0] src);
    logic [4:0] pos;
    pos = 5'h00;
    case (src)
      SRC_EXT_A: pos = 5'h00;
      SRC_TIMER_A: pos = 5'h01;
      SRC_EXT_B: pos = 5'h02;
      SRC_TIMER_B: pos = 5'h03;
      SRC_SERIAL: pos = 5'h04;
      SRC_BROWNOUT: pos = 5'h05;
      SRC_CONVERTER: pos = 5'h06;
      SRC_I2C: pos = PRIO_REG_1_BASE + 5'h00;
      SRC_KEYPAD: pos = PRIO_REG_1_BASE + 5'h01;
      SRC_COMPARATOR: pos = PRIO_REG_1_BASE + 5'h02;
      SRC_BRAKE: pos = PRIO_REG_1_BASE + 5'h02;
      SRC_WATCHDOG: pos = PRIO_REG_1_BASE + 5'h04;
      SRC_PWM: pos = PRIO_REG_1_BASE + 5'h05;
      SRC_CAPTURE: pos = PRIO_REG_1_BASE + 5'h07;
      SRC_TIMER_D: pos = PRIO_REG_2_BASE + 5'h00;
      SRC_SPI: pos = PRIO_REG_2_BASE + 5'h03;
      SRC_TIMER_C: pos = PRIO_REG_2_BASE + 5'h06;
      default: pos = 5'h00;
    endcase
    return pos;
  endfunction : prio_pos

endpackage : irq_ctrl_pkg

// *** hdl/irq_priority_resolver.sv ***
`timescale 1ns/1ps
module irq_priority_resolver
  import irq_ctrl_pkg::*;
(
  // Requests in rank order and their two-bit levels.
  input wire logic [NUM_SOURCES-1:0] request,
  input wire logic [2*NUM_SOURCES-1:0] levels,
  // Winner of this polling cycle.
  output logic winValid,
  output logic [4:0] winIndex,
  output logic [1:0] winLevel
);

  // Highest level first, then the lowest index at that level. Scanning from
  // the bottom rank upward with >= lets the better rank overwrite a tie.
  always_comb begin
    winValid = 1'b0;
    winIndex = 5'h00;
    winLevel = 2'h0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (request[i] && (!winValid || levels[2*i +: 2] >= winLevel)) begin
        winValid = 1'b1;
        winIndex = 5'(i);
        winLevel = levels[2*i +: 2];
      end
    end
  end

endmodule : irq_priority_resolver

// *** sim/irq_controller_props.sv ***
`timescale 1ns/1ps
module irq_controller_props
  import irq_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched inputs.
  input wire logic machineCycleEn,
  input wire enables_type enables,
  input wire logic extPinAEdgeMode,
  input wire core_step_type coreStep,
  input wire logic [15:0] programCounter,
  input wire logic [15:0] stackTop,
  // Watched outputs.
  input wire logic vectorCall,
  input wire logic [15:0] vectorAddr,
  input wire logic stackPushReq,
  input wire logic [15:0] stackPushValue,
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue,
  input wire logic timerAOverflowClear,
  input wire logic extPinAClear,
  input wire logic [NUM_LEVELS-1:0] inService,
  input wire logic [1:0] serviceLevel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Highest marked level; a return from interrupt retires only that one.
  logic [3:0] topBit;
  always_comb begin
    topBit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (inService[i]) begin
        topBit = 4'h1 << i;
      end
    end
  end
  // Steps of the call and return sequences.
  sequence callStart;
    $rose(vectorCall);
  endsequence
  sequence rfiStep;
    machineCycleEn && coreStep.returnFromInterrupt;
  endsequence
  sequence retStep;
    machineCycleEn && coreStep.plainReturn && !coreStep.returnFromInterrupt;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_last_cycle_only:
  assert property (machineCycleEn && !coreStep.lastCycle |=> !vectorCall)
    else $error("Call outside final cycle.");
  a_blocked_step:
  assert property (machineCycleEn && (coreStep.blockVector ||
    coreStep.returnFromInterrupt) |=> !vectorCall)
    else $error("Call in a blocked step.");
  a_global_off:
  assert property (machineCycleEn && !enables.globalIrqEnable |=> !vectorCall)
    else $error("Call with global enable off.");
  a_top_level_kept:
  assert property (machineCycleEn && inService[3] |=> !vectorCall)
    else $error("Top level routine preempted.");
  a_push_with_call:
  assert property (callStart |-> stackPushReq &&
    stackPushValue == $past(programCounter))
    else $error("Push missing or wrong.");
  a_call_marks_level:
  assert property (callStart |-> inService[serviceLevel])
    else $error("Called level not marked.");
  a_rfi_reload:
  assert property (rfiStep |=> pcLoad && pcLoadValue == $past(stackTop) &&
    inService == ($past(inService) & ~$past(topBit)))
    else $error("Bad return from interrupt.");
  a_ret_keeps_mark:
  assert property (retStep |=> pcLoad && ($past(inService) & ~inService) == 0)
    else $error("Plain return changed marks.");
  a_timer_clear:
  assert property (timerAOverflowClear |-> vectorCall &&
    vectorAddr == 16'h000b)
    else $error("Stray timer clear.");
  a_level_pin_kept:
  assert property (machineCycleEn && !extPinAEdgeMode |=> !extPinAClear)
    else $error("Level pin flag cleared.");
  a_hold_between:
  assert property (!machineCycleEn |=> $stable(inService) &&
    $stable(vectorCall))
    else $error("State moved between cycles.");
endmodule : irq_controller_props

bind irq_controller irq_controller_props chk (.core_clk, .rst_n,
  .machineCycleEn, .enables, .extPinAEdgeMode, .coreStep, .programCounter,
  .stackTop, .vectorCall, .vectorAddr, .stackPushReq, .stackPushValue,
  .pcLoad, .pcLoadValue, .timerAOverflowClear, .extPinAClear, .inService,
  .serviceLevel);

// *** sim/core_seq_model.sv ***
`timescale 1ns/1ps
module core_seq_model
  import irq_ctrl_pkg::*;
(
  // Clock, reset and machine-cycle enable.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic machineCycleEn,
  // Instruction status chosen by the bench.
  input wire core_step_type stepWant,
  // Controller requests.
  input wire logic stackPushReq,
  input wire logic [15:0] stackPushValue,
  input wire logic vectorCall,
  input wire logic [15:0] vectorAddr,
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue,
  // Sequencer view seen by the controller.
  output core_step_type coreStep,
  output logic [15:0] programCounter,
  output logic [15:0] stackTop
);
  logic [15:0] stack[$];
  // Final cycle, register writes and returns are flagged as they happen.
  assign coreStep = stepWant;
  // Stack and counter; an empty stack shows a toggling value, not a stale
  // one, so a controller that reads it by mistake is caught.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack.delete();
      programCounter <= 16'h0100;
      stackTop <= 16'h5a5a;
    end else if (machineCycleEn) begin
      if (stackPushReq) begin
        stack.push_back(stackPushValue);
      end
      if ((coreStep.returnFromInterrupt || coreStep.plainReturn) &&
          stack.size() > 0) begin
        void'(stack.pop_back());
      end
      programCounter <= vectorCall ? vectorAddr :
        pcLoad ? pcLoadValue : programCounter + 16'h0001;
      stackTop <= (stack.size() > 0) ? stack[$] : ~stackTop;
    end
  end
endmodule : core_seq_model

// *** sim/test_four_level_interrupt_controller.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_four_level_interrupt_controller
  import irq_ctrl_pkg::*;
;
  logic core_clk, rst_n, machineCycleEn;
  flags_type flags;
  enables_type enables;
  prio_regs_type prios;
  logic extPinAEdgeMode, extPinBEdgeMode, watchdogRcClock, converterRcClock;
  core_step_type coreStep, stepWant;
  logic [15:0] programCounter, stackTop, vectorAddr, stackPushValue;
  logic [15:0] pcLoadValue, expVec, expPush, expLoad;
  logic vectorCall, stackPushReq, pcLoad, wakeRequest, expCall, expLoadP;
  logic timerAOverflowClear, timerBOverflowClear, extPinAClear, extPinBClear;
  logic expTa, expTb, expXa, expXb, expWake;
  logic [3:0] inService, expIns;
  logic [1:0] serviceLevel, expLvl;
  logic [63:0] rnd;
  logic [47:0] pv;
  int failures = 0;
  int compares = 0;
  int seed = 32'h2a40_442e;
  int vecTab[17] = '{'h03, 'h2b, 'h53, 'h0b, 'h4b, 'h33, 'h5b, 'h13, 'h3b,
    'h63, 'h1b, 'h23, 'h7b, 'h83, 'h6b, 'h8b, 'h73};
  int posTab[17] = '{0, 5, 12, 1, 19, 8, 6, 2, 9, 10, 3, 4, 22, 10, 15, 16,
    13};
  ////////////////////////////////////////////////////////////////////////
  irq_controller uut (.core_clk, .rst_n, .machineCycleEn, .flags, .enables,
    .prios, .extPinAEdgeMode, .extPinBEdgeMode, .watchdogRcClock,
    .converterRcClock, .coreStep, .programCounter, .stackTop, .vectorCall,
    .vectorAddr, .stackPushReq, .stackPushValue, .pcLoad, .pcLoadValue,
    .timerAOverflowClear, .timerBOverflowClear, .extPinAClear,
    .extPinBClear, .wakeRequest, .inService, .serviceLevel);
  core_seq_model core (.core_clk, .rst_n, .machineCycleEn, .stepWant,
    .stackPushReq, .stackPushValue, .vectorCall, .vectorAddr, .pcLoad,
    .pcLoadValue, .coreStep, .programCounter, .stackTop);
  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Gated request of each source in rank order.
  function automatic logic [16:0] reqVec();
    logic [16:0] r;
    flags_type f;
    enables_type e;
    f = flags;
    e = enables;
    r[0] = f.extPinAFlag & e.extPinAEnable;
    r[1] = f.brownoutFlag & e.brownoutEnable;
    r[2] = f.watchdogTimeoutFlag & e.watchdogIrqEnable;
    r[3] = f.timerAOverflowFlag & e.timerAEnable;
    r[4] = (f.spiDoneFlag | f.spiModeFaultFlag | f.spiOverrunFlag) &
      e.spiIrqEnable;
    r[5] = f.i2cFlag & e.i2cIrqEnable;
    r[6] = (f.converterDoneFlag & e.converterDoneEnable) |
      (f.converterCompareFlag & e.converterCompareEnable);
    r[7] = f.extPinBFlag & e.extPinBEnable;
    r[8] = f.keypadFlag & e.keypadIrqEnable;
    r[9] = (f.comparatorAFlag | f.comparatorBFlag) & e.comparatorIrqEnable;
    r[10] = f.timerBOverflowFlag & e.timerBEnable;
    r[11] = (f.serialRxFlag | f.serialTxFlag) & e.serialEnable;
    r[12] = f.timerCEventFlag & e.timerCEnable;
    r[13] = (f.brakeAFlag | f.brakeBFlag) & e.brakeIrqEnable;
    r[14] = (|f.captureFlags) & e.captureIrqEnable;
    r[15] = f.timerDEventFlag & e.timerDEnable;
    r[16] = f.pwmPeriodFlag & e.pwmIrqEnable;
    return r & {17{e.globalIrqEnable}};
  endfunction : reqVec
  // Reference model of one clock; outputs other than wake hold while the enable is low.
  task automatic predict();
    logic [16:0] r;
    int w, wl, top, l;
    r = reqVec();
    w = -1;
    wl = -1;
    top = -1;
    for (int s = 16; s >= 0; s--) begin
      l = {prios[24 + posTab[s]], prios[posTab[s]]};
      if (r[s] && l >= wl) begin
        w = s;
        wl = l;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (expIns[i]) top = i;
    end
    expWake = r[0] | r[1] | r[7] | r[8] | r[9] | (r[2] & watchdogRcClock) |
      (flags.converterDoneFlag & enables.converterDoneEnable &
      enables.globalIrqEnable & converterRcClock);
    if (!machineCycleEn) return;
    expCall = w >= 0 && stepWant.lastCycle && !stepWant.blockVector &&
      !stepWant.returnFromInterrupt && wl > top;
    expLoadP = stepWant.returnFromInterrupt | stepWant.plainReturn;
    expLoad = stackTop;
    if (stepWant.returnFromInterrupt && top >= 0) expIns[top] = 1'b0;
    expTa = expCall && w == 3;
    expTb = expCall && w == 10;
    expXa = expCall && w == 0 && extPinAEdgeMode;
    expXb = expCall && w == 7 && extPinBEdgeMode;
    if (expCall) begin
      expVec = 16'(vecTab[w]);
      expPush = programCounter;
      expIns[wl] = 1'b1;
      expLvl = 2'(wl);
    end
  endtask : predict
  // Compare every output with the reference model.
  task automatic check();
    `CHK(vectorCall, expCall)
    `CHK(stackPushReq, expCall)
    `CHK(vectorAddr, expVec)
    `CHK(pcLoad, expLoadP)
    `CHK(timerAOverflowClear, expTa)
    `CHK(timerBOverflowClear, expTb)
    `CHK(extPinAClear, expXa)
    `CHK(extPinBClear, expXb)
    `CHK(inService, expIns)
    `CHK(wakeRequest, expWake)
    if (expLoadP) `CHK(pcLoadValue, expLoad)
    if (expCall) `CHK(stackPushValue, expPush)
    if (expCall) `CHK(serviceLevel, expLvl)
  endtask : check
  // One clock: drive just after the edge, compare after the next one.
  task automatic step(input logic en);
    machineCycleEn = en;
    predict();
    @(posedge core_clk);
    #1;
    check();
  endtask : step
  task automatic resetDut();
    rst_n = 1'b0;
    {expCall, expLoadP, expTa, expTb, expXa, expXb, expWake} = '0;
    {expIns, expVec, expPush, expLoad, expLvl} = '0;
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    check();
  endtask : resetDut
  // Sparse random flags against mostly set enables make ties and preemption frequent.
  task automatic randStep();
    int k;
    rnd = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
    flags = rnd[$bits(flags_type)-1:0];
    enables = ~rnd[63-:$bits(enables_type)];
    rnd = {$random(seed), $random(seed)};
    prios = rnd[47:0];
    {extPinAEdgeMode, extPinBEdgeMode} = rnd[49:48];
    {watchdogRcClock, converterRcClock} = rnd[51:50];
    k = int'(rnd[55:52]);
    // Final cycle must also meet register writes and returns, or the
    // blocking terms of the call decision are never exercised.
    stepWant = '{k > 3 || rnd[59], k == 1, k == 2, k == 3};
    step(rnd[58:56] != 3'h0);
  endtask : randStep
  task summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // Each source in turn at level 3, called and then retired; brake shares the comparator's bit, so comparator wins its turn.
  initial begin
    machineCycleEn = 1'b0;
    {flags, enables, prios, stepWant} = '0;
    {extPinAEdgeMode, extPinBEdgeMode} = 2'h2;
    {watchdogRcClock, converterRcClock} = 2'h0;
    resetDut();
    for (int s = 0; s < 17; s++) begin
      flags = '1;
      enables = '1;
      pv = '0;
      pv[posTab[s]] = 1'b1;
      pv[24 + posTab[s]] = 1'b1;
      prios = pv;
      stepWant = 4'h8;
      step(1'b1);
      stepWant = 4'ha;
      step(1'b1);
    end
    repeat (400) randStep();
    resetDut();
    repeat (400) randStep();
    summarize();
  end
  // Guard against a hang; the main sequence needs far fewer cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    summarize();
  end
endmodule : test_four_level_interrupt_controller
